// file: core/chan_ctl_defines.vh
// constants for the read channel mode and pin control block
// assumes a 250 MHz core clock and pins arriving from outside its domain
`ifndef CHAN_CTL_DEFINES_VH
`define CHAN_CTL_DEFINES_VH

// ==================================================
// mode state codes (one-hot)
`define MODE_W 4
`define MODE_IDLE 4'h1
`define MODE_READ 4'h2
`define MODE_WRITE 4'h4
`define MODE_SERVO 4'h8

// ==================================================
// stream buffer shape
`define FIFO_WIDTH 1
`define FIFO_DEPTH 32
`define FIFO_AW 5

// ==================================================
// synchroniser depth for pin inputs
`define SYNC_W 3

`endif

// file: core/bit_fifo.v
// parameterised FIFO with valid/ready on both sides
// assumes a single clock and a synchronous active-high reset
`timescale 1ns/1ns
`include "chan_ctl_defines.vh"
module bit_fifo #(
    parameter WIDTH = `FIFO_WIDTH,
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW = `FIFO_AW
)
(
    // clock and reset
    input wire clk_i,
    input wire reset_i,
    // fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output reg [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wptr_r;
    reg [AW-1:0] rptr_r;
    reg [AW:0] count_r;
    reg out_valid_r;
    wire push;
    wire pop;
    wire load;
    wire [AW:0] total;

    // the output register counts as one of the DEPTH words
    assign total = count_r + {{AW{1'b0}}, out_valid_r};
    assign in_ready_o = (total != DEPTH[AW:0]);
    assign push = in_valid_i && in_ready_o;
    // output register refills when empty or being taken
    assign load = (count_r != {(AW+1){1'b0}}) && (!out_valid_r || out_ready_i);
    assign pop = out_valid_r && out_ready_i;
    assign out_valid_o = out_valid_r;

    always @(posedge clk_i)
    begin
        if (push)
        begin
            mem_r[wptr_r] <= in_data_i;
        end
        if (reset_i)
        begin
            wptr_r <= {AW{1'b0}};
            rptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
            out_valid_r <= 1'b0;
            out_data_o <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
            begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (load)
            begin
                out_data_o <= mem_r[rptr_r];
                rptr_r <= rptr_r + 1'b1;
                out_valid_r <= 1'b1;
            end
            else if (pop)
            begin
                out_valid_r <= 1'b0;
            end
            if (push && !load)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (!push && load)
            begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // bit_fifo

// file: core/chan_ctl.v
// mode and pin control of a disk read channel
// assumes all pins but test_mode_i are asynchronous to clk_i; the write clock is sampled
// Functional notes
// - servo gain hold low disables the servo charge pump, high lets it run.
// - each peak latch input acquires peaks while low and freezes the cap while high.
// - the active-low cap discharge input discharges both channel caps together.
// - serial write input and serial read output share one wire as a data port.
// - asserting write gate puts the device in write mode while servo gate is high.
// - servo gate low puts the device in servo read mode.
// - raw read pin drives in servo mode or when read and write gates are both low, except in test mode with raw_input_enable set.
// - in test mode with raw_input_enable set the raw pin feeds the data separator.
// - serial read output floats with read gate low and carries read data when high.
`timescale 1ns/1ns
`include "chan_ctl_defines.vh"
module chan_ctl
(
    // clock and reset
    input wire clk_i,
    input wire reset_i,
    // gates from the controller
    input wire read_gate_i,
    input wire write_gate_i,
    input wire servo_gate_n_i,
    // servo controls
    input wire servo_gain_hold_n_i,
    input wire latch_cap_a_i,
    input wire latch_cap_b_i,
    input wire cap_discharge_n_i,
    // test configuration
    input wire test_mode_i,
    input wire raw_input_enable_i,
    // write clock and shared serial data wire
    input wire write_clk_i,
    input wire serial_write_in_i,
    output reg serial_read_o,
    output reg serial_read_oe_o,
    // recovered read data from the separator
    input wire recovered_data_i,
    // raw read data pin
    input wire raw_data_i,
    output reg raw_data_o,
    output reg raw_data_oe_o,
    input wire raw_local_i,
    // analog controls, mode and separator source select
    output reg servo_pump_en_o,
    output reg peak_acq_a_o,
    output reg peak_acq_b_o,
    output reg cap_discharge_o,
    output reg [`MODE_W-1:0] mode_o,
    output reg separator_raw_o,
    // write bit stream to the write path
    output wire write_bit_valid_o,
    input wire write_bit_ready_i,
    output wire write_bit_o,
    output wire write_overrun_o
);
    // ==================================================
    // pin synchronisers
    localparam NPIN = 11;
    wire [NPIN-1:0] pin_raw;
    wire [NPIN-1:0] pin_s;
    assign pin_raw = {raw_data_i, serial_write_in_i, write_clk_i, cap_discharge_n_i,
                      latch_cap_b_i, latch_cap_a_i, servo_gain_hold_n_i,
                      servo_gate_n_i, write_gate_i, read_gate_i, raw_input_enable_i};
    genvar g;
    generate
        for (g = 0; g < NPIN; g = g + 1)
        begin : sync
            reg [`SYNC_W-1:0] sh_r;
            reg stable_r;
            always @(posedge clk_i)
            begin
                if (reset_i)
                begin
                    sh_r <= {`SYNC_W{1'b0}};
                    stable_r <= 1'b0;
                end
                else
                begin
                    sh_r <= {sh_r[`SYNC_W-2:0], pin_raw[g]};
                    if (sh_r[1] == sh_r[2])
                    begin
                        stable_r <= sh_r[2];
                    end
                end
            end
            assign pin_s[g] = stable_r;
        end
    endgenerate

    wire rie_s = pin_s[0];
    wire rg_s = pin_s[1];
    wire wg_s = pin_s[2];
    wire sg_n_s = pin_s[3];
    wire hold_n_s = pin_s[4];
    wire lat_a_s = pin_s[5];
    wire lat_b_s = pin_s[6];
    wire dis_n_s = pin_s[7];
    wire wclk_s = pin_s[8];
    wire wdat_s = pin_s[9];
    wire raw_s = pin_s[10];

    // ==================================================
    // mode selection
    reg [`MODE_W-1:0] mode_nxt;
    always @*
    begin
        if (!sg_n_s)
            mode_nxt = `MODE_SERVO;
        else if (wg_s)
            mode_nxt = `MODE_WRITE;
        else if (rg_s)
            mode_nxt = `MODE_READ;
        else
            mode_nxt = `MODE_IDLE;
    end

    wire raw_in_mode = test_mode_i && rie_s;

    // ==================================================
    // write clock edge and stream into the fifo
    reg wclk_d_r;
    wire wclk_rise = wclk_s && !wclk_d_r;
    wire fifo_in_ready;
    // write bit offered on each rising write clock edge in write mode, dropped as an overrun when the fifo is full
    wire take_bit = wclk_rise && (mode_o == `MODE_WRITE);
    assign write_overrun_o = take_bit && !fifo_in_ready;

    bit_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_fifo (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .in_valid_i(take_bit),
        .in_ready_o(fifo_in_ready),
        .in_data_i(wdat_s),
        .out_valid_o(write_bit_valid_o),
        .out_ready_i(write_bit_ready_i),
        .out_data_o(write_bit_o)
    );

    // ==================================================
    // registered outputs
    always @(posedge clk_i)
    begin
        if (reset_i)
        begin
            wclk_d_r <= 1'b0;
            mode_o <= `MODE_IDLE;
            servo_pump_en_o <= 1'b0;
            peak_acq_a_o <= 1'b0;
            peak_acq_b_o <= 1'b0;
            cap_discharge_o <= 1'b0;
            serial_read_o <= 1'b0;
            serial_read_oe_o <= 1'b0;
            raw_data_o <= 1'b0;
            raw_data_oe_o <= 1'b0;
            separator_raw_o <= 1'b0;
        end
        else
        begin
            wclk_d_r <= wclk_s;
            case (mode_nxt)
                `MODE_IDLE, `MODE_READ, `MODE_WRITE, `MODE_SERVO:
                    mode_o <= mode_nxt;
                default:
                    mode_o <= `MODE_IDLE;
            endcase
            servo_pump_en_o <= hold_n_s;
            peak_acq_a_o <= !lat_a_s;
            peak_acq_b_o <= !lat_b_s;
            cap_discharge_o <= !dis_n_s;
            // shared wire drives only with read gate
            serial_read_oe_o <= rg_s;
            serial_read_o <= rg_s ? recovered_data_i : 1'b0;
            // no drive while a test input
            if (raw_in_mode)
                raw_data_oe_o <= 1'b0;
            else
                raw_data_oe_o <= (!sg_n_s) || (!rg_s && !wg_s);
            raw_data_o <= raw_local_i;
            separator_raw_o <= raw_in_mode ? raw_s : raw_local_i;
        end
    end
endmodule // chan_ctl

// file: tb/chan_ctl_checker.sv
// checker for the pin controls of chan_ctl
// assumes the bench holds pins for several cycles between changes
`timescale 1ns/1ns
module chan_ctl_checker (
    input wire clk_i, reset_i, read_gate_i, write_gate_i, servo_gate_n_i,
    input wire servo_gain_hold_n_i, latch_cap_a_i, latch_cap_b_i, cap_discharge_n_i,
    input wire test_mode_i, raw_input_enable_i, serial_read_oe_o, raw_data_oe_o,
    input wire servo_pump_en_o, peak_acq_a_o, peak_acq_b_o, cap_discharge_o,
    input wire write_overrun_o,
    input wire [3:0] mode_o
);
    reg [3:0] up_r;
    wire [8:0] pins = {read_gate_i, write_gate_i, servo_gate_n_i, servo_gain_hold_n_i,
        latch_cap_a_i, latch_cap_b_i, cap_discharge_n_i, test_mode_i, raw_input_enable_i};
    wire raw_in = test_mode_i && raw_input_enable_i;
    // settle time after reset, synchronisers start at 0
    always @(posedge clk_i)
        up_r <= reset_i ? 4'h0 : up_r + {3'h0, !up_r[3]};
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_st; up_r[3] ##0 $stable(pins)[*6]; endsequence
    property p_pump; s_st |-> servo_pump_en_o == servo_gain_hold_n_i; endproperty
    a_pump: assert property (p_pump) else $error("pump enable wrong");
    property p_acq_a; s_st |-> peak_acq_a_o == !latch_cap_a_i; endproperty
    a_acq_a: assert property (p_acq_a) else $error("peak a wrong");
    property p_acq_b; s_st |-> peak_acq_b_o == !latch_cap_b_i; endproperty
    a_acq_b: assert property (p_acq_b) else $error("peak b wrong");
    property p_dis; s_st |-> cap_discharge_o == !cap_discharge_n_i; endproperty
    a_dis: assert property (p_dis) else $error("discharge wrong");
    property p_wr; s_st ##0 write_gate_i && servo_gate_n_i |-> mode_o == 4'h4; endproperty
    a_wr: assert property (p_wr) else $error("write mode wrong");
    property p_srv; s_st ##0 !servo_gate_n_i |-> mode_o == 4'h8; endproperty
    a_srv: assert property (p_srv) else $error("servo mode wrong");
    property p_raw; s_st ##0 !raw_in |->
        raw_data_oe_o == (!servo_gate_n_i || !(read_gate_i || write_gate_i)); endproperty
    a_raw: assert property (p_raw) else $error("raw drive wrong");
    property p_rin; s_st ##0 raw_in |-> !raw_data_oe_o; endproperty
    a_rin: assert property (p_rin) else $error("raw input driven");
    property p_nrz; s_st ##0 !read_gate_i |-> !serial_read_oe_o; endproperty
    a_nrz: assert property (p_nrz) else $error("read data driven");
    c_wr: cover property (s_st ##0 mode_o == 4'h4);
    c_srv: cover property (s_st ##0 mode_o == 4'h8);
    c_ovr: cover property (write_overrun_o);
endmodule // chan_ctl_checker
bind chan_ctl chan_ctl_checker chk_i (.*);

// file: tb/ctl_partner.sv
// controller model: write clock and write data on the shared wire
// assumes the bench resolves the wire from drive_o, pulled up when free
`timescale 1ns/1ns
module ctl_partner (
    output reg wclk_o,
    output reg data_o,
    output reg drive_o,
    output reg ref_o
);
    initial {wclk_o, data_o, drive_o, ref_o} = 4'h0;
    // data launched at the falling clock edge, write clock from the reference
    // reference toggles six times per bit, three periods per data bit
    task send(input b, input last);
        integer k;
        begin
            drive_o = 1'b1;
            data_o = b;
            for (k = 0; k < 6; k = k + 1)
            begin
                #8 ref_o = !ref_o;
                if (k == 2)
                    wclk_o = 1'b1;
                if (k == 5)
                    wclk_o = 1'b0;
            end
            if (last)
                drive_o = 1'b0;
        end
    endtask
endmodule // ctl_partner

// file: tb/tb_top.sv
// self-checking bench for chan_ctl with a controller model
// assumes pin changes reach the outputs within about five cycles
`timescale 1ns/1ns
module tb_top;
    reg clk_i, reset_i, rg, wg, sg_n, gh_n, la, lb, cd_n, tm, rie, rec, rloc, rpin, rdy, b;
    wire sro, sroe, rdo, rdoe, pump, acq_a, acq_b, dis, sep, bv, bit_o, ovr, wclk, pd, pdrv, rf;
    wire [3:0] mode;
    integer errors, num_checks, seed, i, n, r, ovr_n, ref_n;
    reg [3:0] em;
    reg q[$];
    wire nrz = sroe ? sro : (pdrv ? pd : 1'b1);
    wire raw = rdoe ? rdo : rpin;
    ctl_partner p (.wclk_o(wclk), .data_o(pd), .drive_o(pdrv), .ref_o(rf));
    chan_ctl dut (.clk_i(clk_i), .reset_i(reset_i), .read_gate_i(rg), .write_gate_i(wg),
        .servo_gate_n_i(sg_n), .servo_gain_hold_n_i(gh_n), .latch_cap_a_i(la),
        .latch_cap_b_i(lb), .cap_discharge_n_i(cd_n), .test_mode_i(tm),
        .raw_input_enable_i(rie), .write_clk_i(wclk), .serial_write_in_i(nrz),
        .serial_read_o(sro), .serial_read_oe_o(sroe), .recovered_data_i(rec),
        .raw_data_i(raw), .raw_data_o(rdo), .raw_data_oe_o(rdoe), .raw_local_i(rloc),
        .servo_pump_en_o(pump), .peak_acq_a_o(acq_a), .peak_acq_b_o(acq_b),
        .cap_discharge_o(dis), .mode_o(mode), .separator_raw_o(sep),
        .write_bit_valid_o(bv), .write_bit_ready_i(rdy), .write_bit_o(bit_o),
        .write_overrun_o(ovr));
    initial
    begin
        clk_i = 0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
        if (ovr === 1'b1)
            ovr_n = ovr_n + 1;
    always @(posedge rf)
        ref_n = ref_n + 1;
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp)
            begin
                errors = errors + 1;
                $display("mismatch %0t %h %h", $time, seen, exp);
            end
        end
    endtask
    task give_verdict;
        begin
            if (errors == 0 && num_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task tick(input integer k);
        begin
            repeat (k) @(posedge clk_i);
            #1;
        end
    endtask
    // ==========================================
    // watchdog
    initial
    begin
        #40000;
        errors = errors + 1;
        give_verdict;
    end
    // ==========================================
    // main sequence
    initial
    begin
        {rg, wg, sg_n, gh_n, la, lb, cd_n, tm, rie, rec, rloc, rpin, rdy, b} = 14'h0;
        reset_i = 1;
        {errors, num_checks, ovr_n, ref_n} = 128'h0;
        seed = 32'h60a8;
        tick(12);
        reset_i = 0;
        for (i = 0; i < 60; i = i + 1)
        begin
            r = $random(seed);
            {rg, wg, sg_n, gh_n, la, lb, cd_n, tm, rie, rec, rloc, rpin} = r[11:0];
            // raw pin loops back through the driver before the test input is filtered in
            tick(12);
            em = !sg_n ? 4'h8 : wg ? 4'h4 : rg ? 4'h2 : 4'h1;
            chk({pump, acq_a, acq_b, dis}, {gh_n, !la, !lb, !cd_n});
            chk(mode, em);
            chk(rdoe, !(tm && rie) && (!sg_n || !(rg || wg)));
            chk({rdo, sep}, {rloc, (tm && rie) ? rpin : rloc});
            if (!rg || em == 4'h2)
                chk({sroe, sro}, {rg, rg & rec});
        end
        {rg, wg, sg_n, tm, rdy} = 5'hc;
        tick(8);
        chk(mode, 4'h4);
        for (i = 0; i < 34; i = i + 1)
        begin
            r = $random(seed);
            b = r[0];
            if (i < 32)
                q.push_back(b);
            p.send(b, i == 33);
        end
        tick(4);
        chk({sroe, ovr_n[3:0]}, 5'h2);
        chk(ref_n[7:0], 8'h66);
        for (n = 0; q.size() > 0 && n < 400; n = n + 1)
        begin
            r = $random(seed);
            rdy = r[0];
            if (bv === 1'b1 && rdy)
                chk(bit_o, q.pop_front());
            tick(1);
        end
        tick(3);
        chk({bv, n < 400}, 2'h1);
        give_verdict;
    end
endmodule // tb_top
